// file: port_mib_statistics_counters.sv
/*
 * Per-port receive tail and transmit statistics counters.
 * Assumes one-cycle event pulses from the port MAC and forwarding
 * logic on mclk, with frame qualifiers valid alongside each pulse.
 */
`timescale 1ns/1ps
module port_mib_statistics_counters
    import mib_pkg::*;
#(
    parameter int NCOS = mib_pkg::NUM_COS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Receive carrier events
    input wire logic rx_carrier_end,
    input wire logic rx_symbol_err,
    input wire logic rx_collision,
    input wire logic rx_valid_length,
    // Receive frame end and qualifiers
    input wire logic rx_frame_end,
    input wire logic rx_crc_good,
    input wire logic [mib_pkg::LEN_W-1:0] rx_len_type,
    input wire logic [mib_pkg::LEN_W-1:0] rx_data_octets,
    // Forwarding results
    input wire logic fwd_discard,
    input wire logic fwd_queue_full,
    // Transmit frame end and qualifiers
    input wire logic tx_frame_end,
    input wire logic tx_good,
    input wire logic [mib_pkg::BYTES_W-1:0] tx_bytes,
    input wire logic tx_bcast,
    input wire logic tx_mcast,
    input wire logic [4:0] tx_attempt_collisions,
    input wire logic tx_deferred,
    input wire logic [mib_pkg::COS_W-1:0] tx_cos,
    // Transmit events
    input wire logic tx_collision,
    input wire logic [15:0] tx_bit_time,
    input wire logic tx_underflow,
    input wire logic tx_internal_err,
    input wire logic tx_pause_event,
    // Mode
    input wire logic half_duplex,
    input wire logic qos_enable,
    input wire logic [mib_pkg::NUM_COS-1:0] cos_select,
    // Counter values
    output logic [mib_pkg::CNT_W-1:0] rx_bad_symbol_count,
    output logic [mib_pkg::CNT_W-1:0] rx_forward_discard_count,
    output logic [mib_pkg::CNT_W-1:0] rx_length_mismatch_count,
    output logic [mib_pkg::CNT_W-1:0] rx_length_field_invalid_count,
    output logic [mib_pkg::CNT_W-1:0] tx_dropped_frame_count,
    output logic [mib_pkg::OCT_W-1:0] tx_good_byte_total,
    output logic [mib_pkg::CNT_W-1:0] tx_bcast_frame_count,
    output logic [mib_pkg::CNT_W-1:0] tx_mcast_frame_count,
    output logic [mib_pkg::CNT_W-1:0] tx_collision_total,
    output logic [mib_pkg::CNT_W-1:0] tx_ucast_frame_count,
    output logic [mib_pkg::CNT_W-1:0] tx_one_collision_count,
    output logic [mib_pkg::CNT_W-1:0] tx_many_collision_count,
    output logic [mib_pkg::CNT_W-1:0] tx_deferral_count,
    output logic [mib_pkg::CNT_W-1:0] tx_late_hit_count,
    output logic [mib_pkg::CNT_W-1:0] tx_flow_stop_count,
    output logic [mib_pkg::CNT_W-1:0] queue_full_discard_count,
    output logic [mib_pkg::CNT_W*mib_pkg::NUM_COS-1:0] tx_class_frame_count
);
    import mib_pkg::*;

    localparam int NSC = 15;
    localparam logic [CNT_W-1:0] ONE = 32'h0000_0001;

    // Carrier-event symbol error tracking state
    logic sym_seen_reg;
    logic sym_seen_next;
    logic col_seen_reg;
    logic col_seen_next;

    // Event strobes into counters
    logic [NSC-1:0] inc;
    logic [CNT_W-1:0] cnt [NSC];
    logic late_col;
    logic in_range_err;
    logic out_range_err;
    logic tx_ok;
    logic [NCOS-1:0] cos_inc;

    // Length mismatch test on a good-CRC frame
    function automatic logic len_mismatch(input logic [LEN_W-1:0] lt,
                                          input logic [LEN_W-1:0] got);
        logic r;
        r = 1'b0;
        if (lt >= LEN_MIN_DATA && lt <= LEN_MAX_DATA && lt != got) begin
            r = 1'b1;
        end else if (lt < LEN_MIN_DATA && got > LEN_MIN_DATA) begin
            r = 1'b1;
        end
        return r;
    endfunction : len_mismatch

    // Remember symbol error and collision within one carrier event
    always_comb begin
        sym_seen_next = sym_seen_reg | rx_symbol_err;
        col_seen_next = col_seen_reg | rx_collision;
        if (rx_carrier_end) begin
            sym_seen_next = 1'b0;
            col_seen_next = 1'b0;
        end
    end

    // Register carrier-event flags, cleared at reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sym_seen_reg <= 1'b0;
            col_seen_reg <= 1'b0;
        end else begin
            sym_seen_reg <= sym_seen_next;
            col_seen_reg <= col_seen_next;
        end
    end

    // Frame classification
    assign in_range_err = rx_frame_end && rx_crc_good
        && len_mismatch(rx_len_type, rx_data_octets);
    assign out_range_err = rx_frame_end && rx_crc_good
        && rx_len_type > LEN_MAX_DATA && rx_len_type < TYPE_FIRST;
    assign late_col = tx_collision && (tx_bit_time >= 16'(LATE_BITS));
    assign tx_ok = tx_frame_end && tx_good;

    // Increment strobes, one per counter
    assign inc[0] = rx_carrier_end && rx_valid_length
        && (sym_seen_reg || rx_symbol_err)
        && !(col_seen_reg || rx_collision);
    assign inc[1] = fwd_discard;
    assign inc[2] = in_range_err;
    assign inc[3] = out_range_err;
    assign inc[4] = tx_underflow || (tx_internal_err && !late_col);
    assign inc[5] = tx_ok && tx_bcast;
    assign inc[6] = tx_ok && tx_mcast && !tx_bcast;
    assign inc[7] = tx_collision;
    assign inc[8] = tx_ok && !tx_mcast && !tx_bcast;
    assign inc[9] = tx_ok && tx_attempt_collisions == 5'h01;
    assign inc[10] = tx_ok && tx_attempt_collisions > 5'h01;
    assign inc[11] = tx_frame_end && tx_deferred && half_duplex;
    assign inc[12] = late_col;
    assign inc[13] = tx_pause_event;
    assign inc[14] = fwd_queue_full;

    // Plain event counters
    for (genvar i = 0; i < NSC; i++) begin : g_cnt
        event_counter #(.W(CNT_W)) u_cnt (
            .mclk(mclk),
            .nrst(nrst),
            .inc(inc[i]),
            .amount(ONE),
            .count(cnt[i])
        );
    end

    // Good transmit byte total, FCS included by the MAC's byte count
    event_counter #(.W(OCT_W)) u_octets (
        .mclk(mclk),
        .nrst(nrst),
        .inc(tx_ok),
        .amount({{(OCT_W-BYTES_W){1'b0}}, tx_bytes}),
        .count(tx_good_byte_total)
    );

    // Per class-of-service good frame counts
    for (genvar c = 0; c < NCOS; c++) begin : g_cos
        assign cos_inc[c] = tx_ok && qos_enable && cos_select[c]
            && tx_cos == COS_W'(c);
        event_counter #(.W(CNT_W)) u_cos (
            .mclk(mclk),
            .nrst(nrst),
            .inc(cos_inc[c]),
            .amount(ONE),
            .count(tx_class_frame_count[c*CNT_W +: CNT_W])
        );
    end

    // Counter outputs, plain register reads
    assign rx_bad_symbol_count = cnt[0];
    assign rx_forward_discard_count = cnt[1];
    assign rx_length_mismatch_count = cnt[2];
    assign rx_length_field_invalid_count = cnt[3];
    assign tx_dropped_frame_count = cnt[4];
    assign tx_bcast_frame_count = cnt[5];
    assign tx_mcast_frame_count = cnt[6];
    assign tx_collision_total = cnt[7];
    assign tx_ucast_frame_count = cnt[8];
    assign tx_one_collision_count = cnt[9];
    assign tx_many_collision_count = cnt[10];
    assign tx_deferral_count = cnt[11];
    assign tx_late_hit_count = cnt[12];
    assign tx_flow_stop_count = cnt[13];
    assign queue_full_discard_count = cnt[14];

    // Checks
    AST_SYMBOL: assert property (@(posedge mclk) disable iff (!nrst)
        rx_carrier_end && rx_collision |=> $stable(rx_bad_symbol_count))
        else $error("symbol count rose on collision event");
    AST_DISCARD: assert property (@(posedge mclk) disable iff (!nrst)
        fwd_discard |=> rx_forward_discard_count == $past(rx_forward_discard_count) + ONE)
        else $error("discard count missed");
    AST_INRANGE: assert property (@(posedge mclk) disable iff (!nrst)
        rx_frame_end && !rx_crc_good |=> $stable(rx_length_mismatch_count))
        else $error("length mismatch counted on bad crc");
    AST_OUTRANGE: assert property (@(posedge mclk) disable iff (!nrst)
        rx_frame_end && rx_crc_good && rx_len_type == 16'h05DD
        |=> rx_length_field_invalid_count == $past(rx_length_field_invalid_count) + ONE)
        else $error("out of range length missed");
    AST_DROP: assert property (@(posedge mclk) disable iff (!nrst)
        tx_underflow |=> tx_dropped_frame_count != $past(tx_dropped_frame_count))
        else $error("drop missed");
    AST_OCTETS: assert property (@(posedge mclk) disable iff (!nrst)
        tx_ok |=> tx_good_byte_total
            == $past(tx_good_byte_total) + {{(OCT_W-BYTES_W){1'b0}}, $past(tx_bytes)})
        else $error("byte total wrong");
    AST_BCAST: assert property (@(posedge mclk) disable iff (!nrst)
        tx_frame_end && !tx_good |=> $stable(tx_bcast_frame_count))
        else $error("errored broadcast counted");
    AST_LATE: assert property (@(posedge mclk) disable iff (!nrst)
        tx_collision && tx_bit_time < 16'h0200 |=> $stable(tx_late_hit_count))
        else $error("early collision counted late");
    AST_DEFER: assert property (@(posedge mclk) disable iff (!nrst)
        !half_duplex |=> $stable(tx_deferral_count))
        else $error("deferral counted in full duplex");
    AST_RESET: assert property (@(posedge mclk)
        $rose(nrst) |-> tx_collision_total == CNT_RESET)
        else $error("counter not zero after reset");
    COV_LATE: cover property (@(posedge mclk) disable iff (!nrst) late_col);
    COV_SYM: cover property (@(posedge mclk) disable iff (!nrst) inc[0]);
    COV_COS5: cover property (@(posedge mclk) disable iff (!nrst) cos_inc[NCOS-1]);
    COV_DEFER: cover property (@(posedge mclk) disable iff (!nrst) inc[11]);
    COV_MANY: cover property (@(posedge mclk) disable iff (!nrst) inc[10]);

    // Further rule checks, one cycle after each event
    AST_SYMBOL_ONCE: assert property (@(posedge mclk) disable iff (!nrst)
        rx_carrier_end && rx_valid_length && rx_symbol_err && !rx_collision && !col_seen_reg
        |=> rx_bad_symbol_count == $past(rx_bad_symbol_count) + ONE)
        else $error("symbol error event missed");
    AST_INRANGE_HIT: assert property (@(posedge mclk) disable iff (!nrst)
        rx_frame_end && rx_crc_good && rx_len_type >= LEN_MIN_DATA
        && rx_len_type <= LEN_MAX_DATA && rx_len_type != rx_data_octets
        |=> rx_length_mismatch_count == $past(rx_length_mismatch_count) + ONE)
        else $error("length mismatch missed");
    AST_TYPE_FIELD: assert property (@(posedge mclk) disable iff (!nrst)
        rx_frame_end && rx_len_type >= TYPE_FIRST |=> $stable(rx_length_field_invalid_count))
        else $error("type value counted as length error");
    AST_DROP_LATE: assert property (@(posedge mclk) disable iff (!nrst)
        tx_internal_err && !tx_underflow && tx_collision && tx_bit_time >= 16'(LATE_BITS)
        |=> $stable(tx_dropped_frame_count))
        else $error("late collision counted as drop");
    AST_MCAST: assert property (@(posedge mclk) disable iff (!nrst)
        tx_frame_end && tx_good && tx_mcast && !tx_bcast
        |=> tx_mcast_frame_count == $past(tx_mcast_frame_count) + ONE)
        else $error("multicast frame missed");
    AST_MCAST_EXCL: assert property (@(posedge mclk) disable iff (!nrst)
        tx_frame_end && (tx_bcast || !tx_good) |=> $stable(tx_mcast_frame_count))
        else $error("broadcast or errored frame counted as multicast");
    AST_COLL: assert property (@(posedge mclk) disable iff (!nrst)
        tx_collision |=> tx_collision_total == $past(tx_collision_total) + ONE)
        else $error("collision missed");
    AST_UCAST: assert property (@(posedge mclk) disable iff (!nrst)
        tx_frame_end && (tx_bcast || tx_mcast) |=> $stable(tx_ucast_frame_count))
        else $error("group frame counted as unicast");
    AST_ONE_COLL: assert property (@(posedge mclk) disable iff (!nrst)
        tx_frame_end && tx_good && tx_attempt_collisions == 5'h01
        |=> tx_one_collision_count == $past(tx_one_collision_count) + ONE)
        else $error("single collision frame missed");
    AST_MANY_COLL: assert property (@(posedge mclk) disable iff (!nrst)
        tx_frame_end && tx_attempt_collisions < 5'h02 |=> $stable(tx_many_collision_count))
        else $error("multiple collision counted too early");
    AST_LATE_HIT: assert property (@(posedge mclk) disable iff (!nrst)
        tx_collision && tx_bit_time >= 16'(LATE_BITS)
        |=> tx_late_hit_count == $past(tx_late_hit_count) + ONE)
        else $error("late collision missed");
    AST_PAUSE: assert property (@(posedge mclk) disable iff (!nrst)
        tx_pause_event |=> tx_flow_stop_count == $past(tx_flow_stop_count) + ONE)
        else $error("pause event missed");
    AST_QFULL: assert property (@(posedge mclk) disable iff (!nrst)
        fwd_queue_full |=> queue_full_discard_count == $past(queue_full_discard_count) + ONE)
        else $error("queue full discard missed");
    AST_COS_OFF: assert property (@(posedge mclk) disable iff (!nrst)
        !qos_enable |=> $stable(tx_class_frame_count))
        else $error("class count moved with qos off");
    AST_COS_HIT: assert property (@(posedge mclk) disable iff (!nrst)
        tx_frame_end && tx_good && qos_enable && cos_select[0] && tx_cos == '0
        |=> tx_class_frame_count[CNT_W-1:0] == $past(tx_class_frame_count[CNT_W-1:0]) + ONE)
        else $error("class zero frame missed");
endmodule : port_mib_statistics_counters

// file: mib_pkg.sv
/*
 * Shared constants for the per-port statistics counter block.
 * Assumes a single core clock; no software register map.
 */
package mib_pkg;
    localparam int CNT_W = 32;
    localparam int OCT_W = 64;
    localparam int LEN_W = 16;
    localparam int BYTES_W = 14;
    localparam int NUM_COS = 6;
    localparam int COS_W = 3;
    localparam logic [LEN_W-1:0] LEN_MIN_DATA = 16'h002E;
    localparam logic [LEN_W-1:0] LEN_MAX_DATA = 16'h05DC;
    localparam logic [LEN_W-1:0] TYPE_FIRST = 16'h0600;
    localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
    localparam logic [OCT_W-1:0] OCT_RESET = 64'h0000_0000_0000_0000;
    localparam logic [COS_W-1:0] COS_LAST = 3'h5;
    localparam int LATE_BITS = 512;
endpackage : mib_pkg

// file: event_counter.sv
/*
 * One wrapping statistics counter with increment and add amount.
 * Assumes increment inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module event_counter #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Event
    input wire logic inc,
    input wire logic [W-1:0] amount,
    // Value
    output logic [W-1:0] count
);
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;

    // Add amount on event, wrap modulo width
    always_comb begin
        count_next = count_reg;
        if (inc) begin
            count_next = count_reg + amount;
        end
    end

    // Register, cleared at reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    // Counter value out, straight from the register
    assign count = count_reg;
endmodule : event_counter

// file: event_source.sv
/*
 * Model of the port MAC and forwarding logic that feeds frame events.
 * Assumes the bench sets one event descriptor and a fire strobe at the
 * falling edge of mclk; outside a fire, qualifiers carry a moving pattern.
 */
`timescale 1ns/1ps
module event_source (
    // Clock
    input wire logic mclk,
    // Descriptor from the bench
    input wire logic fire,
    input wire logic [9:0] pl,
    input wire logic [6:0] fl,
    input wire logic [15:0] a,
    input wire logic [15:0] b,
    input wire logic [4:0] n,
    input wire logic [2:0] c,
    // Event pulses and qualifiers
    output logic [9:0] ev,
    output logic [6:0] qf,
    output logic [15:0] qa,
    output logic [15:0] qb,
    output logic [4:0] qn,
    output logic [2:0] qc
);
    logic [15:0] sc = 16'h5A5A;

    // Idle pattern so stale qualifiers never look valid
    always_ff @(negedge mclk) begin
        sc <= ~sc + 16'h1357;
    end

    // Pulses only during a fire; qualifiers scrambled otherwise
    assign ev = fire ? pl : 10'h000;
    assign qf = fire ? fl : sc[6:0];
    assign qa = fire ? a : sc;
    assign qb = fire ? b : ~sc;
    assign qn = fire ? n : sc[4:0];
    assign qc = fire ? c : sc[2:0];
endmodule : event_source

// file: test_port_mib_statistics_counters.sv
/*
 * Self-checking bench for the per-port statistics counters.
 * Assumes event_source drives the event ports; counts seen one cycle on.
 */
`timescale 1ns/1ps
module test_port_mib_statistics_counters;
    import mib_pkg::*;
    typedef struct packed {
        logic [9:0] pl; logic [6:0] fl; logic [15:0] a; logic [15:0] b;
        logic [4:0] n; logic [2:0] c; logic [4:0] ix; logic [31:0] ex;
    } row_t;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic fire = 1'b0;
    logic hd = 1'b1;
    logic qe = 1'b0;
    logic [5:0] cs = 6'h3F;
    row_t rr = '0;
    logic [9:0] ev;
    logic [6:0] qf;
    logic [15:0] qa, qb;
    logic [4:0] qn;
    logic [2:0] qc;
    logic [735:0] cv;
    int failures = 0;
    int checks_done = 0;
    row_t rows [29] = '{
        '{10'h003, 7'h02, 16'h0, 16'h0, 5'h0, 3'h0, 5'h00, 32'h1},
        '{10'h003, 7'h03, 16'h0, 16'h0, 5'h0, 3'h0, 5'h00, 32'h1},
        '{10'h003, 7'h00, 16'h0, 16'h0, 5'h0, 3'h0, 5'h00, 32'h1},
        '{10'h008, 7'h00, 16'h0, 16'h0, 5'h0, 3'h0, 5'h01, 32'h1},
        '{10'h004, 7'h04, 16'h0064, 16'h0050, 5'h0, 3'h0, 5'h02, 32'h1},
        '{10'h004, 7'h04, 16'h002E, 16'h002E, 5'h0, 3'h0, 5'h02, 32'h1},
        '{10'h004, 7'h04, 16'h05DC, 16'h05DB, 5'h0, 3'h0, 5'h02, 32'h2},
        '{10'h004, 7'h04, 16'h002D, 16'h002F, 5'h0, 3'h0, 5'h02, 32'h3},
        '{10'h004, 7'h04, 16'h002D, 16'h002E, 5'h0, 3'h0, 5'h02, 32'h3},
        '{10'h004, 7'h00, 16'h0064, 16'h0050, 5'h0, 3'h0, 5'h02, 32'h3},
        '{10'h004, 7'h04, 16'h05DD, 16'h0, 5'h0, 3'h0, 5'h03, 32'h1},
        '{10'h004, 7'h04, 16'h05FF, 16'h0, 5'h0, 3'h0, 5'h03, 32'h2},
        '{10'h004, 7'h04, 16'h0600, 16'h0, 5'h0, 3'h0, 5'h03, 32'h2},
        '{10'h004, 7'h00, 16'h05DD, 16'h0, 5'h0, 3'h0, 5'h03, 32'h2},
        '{10'h080, 7'h00, 16'h0, 16'h0, 5'h0, 3'h0, 5'h04, 32'h1},
        '{10'h100, 7'h00, 16'h0, 16'h0, 5'h0, 3'h0, 5'h04, 32'h2},
        '{10'h140, 7'h00, 16'h0258, 16'h0, 5'h0, 3'h0, 5'h04, 32'h2},
        '{10'h040, 7'h00, 16'h0200, 16'h0, 5'h0, 3'h0, 5'h0E, 32'h2},
        '{10'h040, 7'h00, 16'h01FF, 16'h0, 5'h0, 3'h0, 5'h09, 32'h3},
        '{10'h020, 7'h18, 16'h0, 16'h0040, 5'h0, 3'h0, 5'h07, 32'h1},
        '{10'h020, 7'h28, 16'h0, 16'h0040, 5'h0, 3'h0, 5'h08, 32'h1},
        '{10'h020, 7'h38, 16'h0, 16'h0040, 5'h0, 3'h0, 5'h07, 32'h2},
        '{10'h020, 7'h08, 16'h0, 16'h0040, 5'h0, 3'h0, 5'h0A, 32'h1},
        '{10'h020, 7'h10, 16'h0, 16'h0040, 5'h0, 3'h0, 5'h05, 32'h100},
        '{10'h020, 7'h08, 16'h0, 16'h0040, 5'h1, 3'h0, 5'h0B, 32'h1},
        '{10'h020, 7'h08, 16'h0, 16'h0040, 5'h2, 3'h0, 5'h0C, 32'h1},
        '{10'h020, 7'h48, 16'h0, 16'h0040, 5'h0, 3'h0, 5'h0D, 32'h1},
        '{10'h200, 7'h00, 16'h0, 16'h0, 5'h0, 3'h0, 5'h0F, 32'h1},
        '{10'h010, 7'h00, 16'h0, 16'h0, 5'h0, 3'h0, 5'h10, 32'h1}
    };

    // Clock, 25 ns period
    always #12.5 mclk = ~mclk;

    event_source src_u (.mclk(mclk), .fire(fire), .pl(rr.pl), .fl(rr.fl), .a(rr.a),
        .b(rr.b), .n(rr.n), .c(rr.c), .ev(ev), .qf(qf), .qa(qa), .qb(qb), .qn(qn), .qc(qc));

    port_mib_statistics_counters dut_u (.mclk(mclk), .nrst(nrst),
        .rx_carrier_end(ev[0]), .rx_symbol_err(ev[1]), .rx_frame_end(ev[2]),
        .fwd_discard(ev[3]), .fwd_queue_full(ev[4]), .tx_frame_end(ev[5]),
        .tx_collision(ev[6]), .tx_underflow(ev[7]), .tx_internal_err(ev[8]),
        .tx_pause_event(ev[9]), .rx_collision(qf[0]), .rx_valid_length(qf[1]),
        .rx_crc_good(qf[2]), .tx_good(qf[3]), .tx_bcast(qf[4]), .tx_mcast(qf[5]),
        .tx_deferred(qf[6]), .rx_len_type(qa), .tx_bit_time(qa), .rx_data_octets(qb),
        .tx_bytes(qb[13:0]), .tx_attempt_collisions(qn), .tx_cos(qc),
        .half_duplex(hd), .qos_enable(qe), .cos_select(cs),
        .rx_bad_symbol_count(cv[31:0]), .rx_forward_discard_count(cv[63:32]),
        .rx_length_mismatch_count(cv[95:64]), .rx_length_field_invalid_count(cv[127:96]),
        .tx_dropped_frame_count(cv[159:128]), .tx_good_byte_total(cv[223:160]),
        .tx_bcast_frame_count(cv[255:224]), .tx_mcast_frame_count(cv[287:256]),
        .tx_collision_total(cv[319:288]), .tx_ucast_frame_count(cv[351:320]),
        .tx_one_collision_count(cv[383:352]), .tx_many_collision_count(cv[415:384]),
        .tx_deferral_count(cv[447:416]), .tx_late_hit_count(cv[479:448]),
        .tx_flow_stop_count(cv[511:480]), .queue_full_discard_count(cv[543:512]),
        .tx_class_frame_count(cv[735:544]));

    // Compare one 32-bit counter word
    task chk(input int ix, input logic [31:0] ex);
        checks_done++;
        if (cv[ix*32+:32] !== ex) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, cv[ix*32+:32], ex);
        end
    endtask : chk

    // Compare the 64-bit byte total
    task chk64(input logic [63:0] ex);
        checks_done++;
        if (cv[223:160] !== ex) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, cv[223:160], ex);
        end
    endtask : chk64

    // Fire a descriptor for k cycles, then compare at the falling edge that ends the fire
    task go(input row_t r, input int k);
        rr = r;
        fire = 1'b1;
        repeat (k) @(negedge mclk);
        fire = 1'b0;
        chk(r.ix, r.ex);
    endtask : go

    // Verdict and end of run
    task results;
        if (failures == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // Main sequence
    initial begin
        repeat (3) @(negedge mclk);
        nrst = 1'b1;
        foreach (rows[i]) go(rows[i], 1);
        chk64(64'h1C0);
        chk(8, 32'h1);
        chk(14, 32'h2);
        go('{10'h002, 7'h00, 16'h0, 16'h0, 5'h0, 3'h0, 5'h00, 32'h1}, 2);
        go('{10'h001, 7'h02, 16'h0, 16'h0, 5'h0, 3'h0, 5'h00, 32'h2}, 1);
        go('{10'h002, 7'h01, 16'h0, 16'h0, 5'h0, 3'h0, 5'h00, 32'h2}, 1);
        go('{10'h001, 7'h02, 16'h0, 16'h0, 5'h0, 3'h0, 5'h00, 32'h2}, 1);
        go('{10'h140, 7'h00, 16'h01FF, 16'h0, 5'h0, 3'h0, 5'h04, 32'h3}, 1);
        hd = 1'b0;
        go('{10'h020, 7'h48, 16'h0, 16'h40, 5'h0, 3'h0, 5'h0D, 32'h1}, 1);
        go('{10'h200, 7'h00, 16'h0, 16'h0, 5'h0, 3'h0, 5'h0F, 32'h3}, 2);
        qe = 1'b1;
        cs = 6'h2F;
        for (int c = 0; c < 6; c++) begin
            go('{10'h020, 7'h08, 16'h0, 16'h40, 5'h0, c[2:0], 5'(17 + c), 32'(c != 4)}, 1);
        end
        qe = 1'b0;
        go('{10'h020, 7'h08, 16'h0, 16'h40, 5'h0, 3'h0, 5'h11, 32'h1}, 1);
        nrst = 1'b0;
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        for (int i = 0; i < 23; i++) chk(i, 32'h0);
        go('{10'h200, 7'h00, 16'h0, 16'h0, 5'h0, 3'h0, 5'h0F, 32'h1}, 1);
        results();
    end
endmodule : test_port_mib_statistics_counters
